// >>> dv/board_model.sv
`timescale 1ns/1ps
module board_model
  import pin_mux_pkg::*;
(
  // Clock
  input wire logic clk,
  // Device pad drive
  input wire logic [NUM_PADS-1:0] pad_out,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [NUM_PADS-1:0] pad_pull_up,
  // Board-side drivers
  input wire logic [NUM_PADS-1:0] ext_val,
  input wire logic [NUM_PADS-1:0] ext_oe,
  // Resolved pad level
  output logic [NUM_PADS-1:0] pad_in
);
  logic [NUM_PADS-1:0] flt_r = '0;

  // Undriven pads without pull-up wander every cycle, so a stale level never passes
  always @(posedge clk) begin
    flt_r <= ~flt_r;
  end

  // Device drive wins, then the board, then pull-up or wander
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val) |
                  (~pad_oe & ~ext_oe & (pad_pull_up | flt_r));
endmodule : board_model

// >>> dv/pin_function_mux_tb.sv
`timescale 1ns/1ps
module pin_function_mux_tb
  import pin_mux_pkg::*;
;
  logic clk = 0;
  logic nrst = 0;
  logic sel_we = 0;
  logic serial_peripheral_port_1_master = 0;
  logic serial_comm_port_1_single_wire = 0;
  logic tck_pin = 0;
  logic tdo_data = 0;
  logic [PAD_W-1:0] sel_pad = '0;
  logic [SEL_W-1:0] sel_val = '0;
  logic [NUM_PADS-1:0] gpio_dout = '0;
  logic [NUM_PADS-1:0] gpio_dir = '0;
  logic [NUM_PADS-1:0] ext_val = '0;
  logic [NUM_PADS-1:0] ext_oe = '0;
  logic [NUM_PADS-1:0] gpio_din, pad_in, pad_out, pad_oe, pad_pull_up;
  logic [NUM_PADS-1:0][NUM_FN-1:0] periph_dout = '0;
  logic [NUM_PADS-1:0][NUM_FN-1:0] periph_oe = '0;
  logic [NUM_PADS-1:0][NUM_FN-1:0] periph_din;
  logic [CLK_SRC_W-1:0] clock_out_source_field = '0;
  logic [CLK_SRC_N-1:0] clk_src = '0;
  logic tap_shift;
  tap_bits_t tap_bits;
  logic smp_tms, smp_tdi;
  int fails = 0;
  int checked = 0;
  int smp_n = 0;

  always #2 clk = ~clk;

  pin_function_mux dut (.clk, .nrst, .sel_we, .sel_pad, .sel_val, .gpio_dout, .gpio_dir,
    .gpio_din, .periph_dout, .periph_oe, .periph_din, .serial_peripheral_port_1_master, .serial_comm_port_1_single_wire,
    .clock_out_source_field, .clk_src, .tck_pin, .tdo_data, .tap_shift, .tap_bits,
    .pad_in, .pad_out, .pad_oe, .pad_pull_up);

  board_model board (.clk, .pad_out, .pad_oe, .pad_pull_up, .ext_val, .ext_oe, .pad_in);

  // Catch each debug sample pulse
  always @(posedge clk) begin
    if (tap_bits.sample === 1'b1) begin
      smp_n++;
      smp_tms = tap_bits.tms;
      smp_tdi = tap_bits.tdi;
    end
  end

  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic chk1(input logic s, input logic e);
    chk({11'h0, s}, {11'h0, e});
  endtask : chk1

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic sel_wr(input int p, input int v);
    @(posedge clk);
    sel_we <= 1'b1;
    sel_pad <= PAD_W'(p);
    sel_val <= SEL_W'(v);
    @(posedge clk);
    sel_we <= 1'b0;
    step(4);
  endtask : sel_wr

  task automatic tck_rise(input logic m, input logic d);
    int n0;
    @(posedge clk);
    ext_val[10] <= m;
    ext_val[11] <= d;
    step(4);
    n0 = smp_n;
    @(posedge clk);
    tck_pin <= 1'b1;
    step(6);
    chk(12'(smp_n - n0), 12'h001);
    chk1(smp_tms, m);
    chk1(smp_tdi, d);
  endtask : tck_rise

  task automatic tck_fall;
    @(posedge clk);
    tck_pin <= 1'b0;
    step(6);
  endtask : tck_fall

  task automatic test_gpio;
    logic [8:0] pat [2] = '{9'h0A5, 9'h15A};
    chk(pad_oe, 12'h000);
    chk(pad_pull_up, 12'hC00);
    chk(pad_pull_up & 12'h800, 12'h800);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      gpio_dir <= {3'b111, pat[k]};
      gpio_dout <= 12'h3C9;
      ext_oe <= {3'b000, ~pat[k]};
      ext_val <= 12'h555;
      step(5);
      chk(pad_oe, {3'b000, pat[k]});
      chk(pad_out & pad_oe, gpio_dout & gpio_dir & 12'h1FF);
      chk(gpio_din, ((gpio_dout & gpio_dir) | (ext_val & ~gpio_dir)) & 12'h1FF);
    end
    $display("gpio test done");
  endtask : test_gpio

  task automatic test_fault_sci;
    @(posedge clk);
    gpio_dir <= '1;
    periph_oe <= '1;
    ext_oe <= 12'h004;
    sel_wr(PAD_F4, 4);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      ext_val[2] <= v[0];
      step(5);
      chk1(pad_oe[2], 1'b0);
      chk1(periph_din[2][4], v[0]);
      chk1(periph_din[2][1], 1'b0);
      chk1(gpio_din[2], 1'b0);
    end
    @(posedge clk);
    periph_oe <= '0;
    periph_dout[2][1] <= 1'b1;
    ext_oe <= '0;
    sel_wr(PAD_F4, 1);
    chk1(pad_oe[2], 1'b1);
    chk1(pad_out[2], 1'b1);
    @(posedge clk);
    serial_comm_port_1_single_wire <= 1'b1;
    ext_oe <= 12'h004;
    ext_val[2] <= 1'b1;
    step(5);
    chk1(pad_oe[2], 1'b0);
    chk1(periph_din[2][1], 1'b1);
    $display("fault and serial test done");
  endtask : test_fault_sci

  task automatic test_spi;
    sel_wr(PAD_F2, 3);
    sel_wr(PAD_F3, 3);
    sel_wr(PAD_F7, 3);
    @(posedge clk);
    periph_dout[0][3] <= 1'b1;
    periph_dout[1][3] <= 1'b1;
    ext_oe <= 12'h082;
    ext_val <= 12'h082;
    step(5);
    chk1(pad_oe[0], 1'b0);
    chk1(pad_oe[1], 1'b0);
    chk1(periph_din[1][3], 1'b1);
    @(posedge clk);
    ext_val[7] <= 1'b0;
    step(5);
    chk1(periph_din[7][3], 1'b0);
    chk1(pad_oe[0], 1'b1);
    chk1(pad_out[0], 1'b1);
    @(posedge clk);
    serial_peripheral_port_1_master <= 1'b1;
    ext_oe <= 12'h081;
    ext_val <= 12'h001;
    step(5);
    chk1(pad_oe[0], 1'b0);
    chk1(periph_din[0][3], 1'b1);
    chk1(pad_oe[1], 1'b1);
    chk1(pad_out[1], 1'b1);
    $display("spi test done");
  endtask : test_spi

  task automatic test_clk_pwm;
    sel_wr(PAD_F1, 1);
    for (int f = 0; f < CLK_SRC_N; f++) begin
      @(posedge clk);
      clock_out_source_field <= CLK_SRC_W'(f);
      clk_src <= CLK_SRC_N'(1 << f);
      step(3);
      chk1(pad_oe[6], 1'b1);
      chk1(pad_out[6], 1'b1);
      @(posedge clk);
      clk_src <= ~CLK_SRC_N'(1 << f);
      step(3);
      chk1(pad_out[6], 1'b0);
    end
    sel_wr(PAD_E0, 1);
    @(posedge clk);
    periph_oe[4][1] <= 1'b1;
    periph_dout[4][1] <= 1'b1;
    ext_oe <= '0;
    step(3);
    chk1(pad_oe[4], 1'b1);
    chk1(pad_out[4], 1'b1);
    @(posedge clk);
    periph_oe[4][1] <= 1'b0;
    ext_oe <= 12'h010;
    ext_val <= 12'h010;
    step(5);
    chk1(pad_oe[4], 1'b0);
    chk1(periph_din[4][1], 1'b1);
    @(posedge clk);
    periph_oe <= '1;
    sel_wr(PAD_E0, 5);
    chk1(pad_oe[4], 1'b0);
    $display("clock-out and pwm test done");
  endtask : test_clk_pwm

  task automatic test_debug;
    @(posedge clk);
    periph_oe <= '0;
    ext_oe <= 12'hC00;
    tdo_data <= 1'b1;
    tck_rise(0, 1);
    tck_fall();
    tck_rise(1, 0);
    tck_fall();
    tck_rise(0, 1);
    tck_fall();
    chk1(pad_oe[9], 1'b0);
    tck_rise(0, 0);
    chk1(tap_shift, 1'b1);
    chk1(pad_oe[9], 1'b0);
    tck_fall();
    chk1(pad_oe[9], 1'b1);
    chk1(pad_out[9], 1'b1);
    @(posedge clk);
    tdo_data <= 1'b0;
    tck_rise(0, 1);
    chk1(pad_out[9], 1'b1);
    tck_fall();
    chk1(pad_out[9], 1'b0);
    tck_rise(1, 1);
    chk1(pad_oe[9], 1'b1);
    tck_fall();
    chk1(pad_oe[9], 1'b0);
    sel_wr(PAD_TDO, 1);
    sel_wr(PAD_TMS, 1);
    chk1(pad_oe[9], gpio_dir[9]);
    chk1(pad_pull_up[10], 1'b0);
    $display("debug test done");
  endtask : test_debug

  task automatic test_alt;
    @(posedge clk);
    periph_oe <= '0;
    periph_dout <= '1;
    ext_oe <= 12'h028;
    ext_val <= 12'h028;
    sel_wr(PAD_F2, 2);
    sel_wr(PAD_F5, 1);
    sel_wr(PAD_E1, 1);
    sel_wr(PAD_C13, 3);
    sel_wr(PAD_TDI, 1);
    step(2);
    chk(pad_oe & 12'h129, 12'h101);
    chk(pad_out & 12'h101, 12'h101);
    chk1(periph_din[3][1], 1'b1);
    chk1(periph_din[3][4], 1'b0);
    chk1(periph_din[0][2], 1'b0);
    chk1(periph_din[5][1], 1'b1);
    chk1(pad_oe[5], 1'b0);
    chk1(periph_din[11][0], 1'b1);
    chk1(pad_pull_up[11], 1'b0);
    chk1(pad_oe[11], 1'b1);
    $display("alternate function test done");
  endtask : test_alt

  task automatic test_done;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  initial begin
    #80000;
    fails++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    step(3);
    test_gpio();
    test_fault_sci();
    test_spi();
    test_clk_pwm();
    test_debug();
    test_alt();
    test_done();
  end
endmodule : pin_function_mux_tb

// >>> hdl/pin_function_mux.sv
`timescale 1ns/1ps
// Functional notes
// RQ1: After reset every port pad is general-purpose I/O until software reselects it.
// RQ2: Each general-purpose pad has its own direction bit.
// RQ3: TDO, TMS and TDI pads default to debug; each may become port D I/O.
// RQ4: TDO floats outside Shift-IR/DR; when driven it changes on falling TCK.
// RQ5: TMS is sampled on rising TCK to step the TAP; pad pulled up.
// RQ6: TDI is sampled on rising TCK as debug serial input; pad pulled up.
// RQ7: MISO floats when slave and deselected; input as master, output as slave.
// RQ8: MOSI is output as master and input as slave.
// RQ9: An external master asserts slave select to address this slave.
// RQ10: Clock-out pad drives a buffered clock picked by the source field.
// RQ11: Serial transmit pad works as plain output or single-wire shared line.
// RQ12: PWM pad function is bidirectional: output or input capture.
// RQ13: One select per pad; only selected function reaches pad; others see idle.
// RQ14: PWM fault function forwards pad level and never drives the pad.
module pin_function_mux
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Multiplexer select writes
  input wire logic sel_we,
  input wire logic [PAD_W-1:0] sel_pad,
  input wire logic [SEL_W-1:0] sel_val,
  // Port general-purpose I/O
  input wire logic [NUM_PADS-1:0] gpio_dout,
  input wire logic [NUM_PADS-1:0] gpio_dir,
  output logic [NUM_PADS-1:0] gpio_din,
  // Peripheral functions
  input wire logic [NUM_PADS-1:0][NUM_FN-1:0] periph_dout,
  input wire logic [NUM_PADS-1:0][NUM_FN-1:0] periph_oe,
  output logic [NUM_PADS-1:0][NUM_FN-1:0] periph_din,
  input wire logic serial_peripheral_port_1_master,
  input wire logic serial_comm_port_1_single_wire,
  input wire logic [CLK_SRC_W-1:0] clock_out_source_field,
  input wire logic [CLK_SRC_N-1:0] clk_src,
  // Debug port
  input wire logic tck_pin,
  input wire logic tdo_data,
  output logic tap_shift,
  output tap_bits_t tap_bits,
  // Pads
  input wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe,
  output logic [NUM_PADS-1:0] pad_pull_up
);

  logic rst_s1_r, rst_n_r;
  logic [NUM_PADS-1:0] pin_s1_r, pin_s2_r;
  logic [NUM_PADS-1:0][SEL_W-1:0] sel_r;
  logic ss_sel, tms_tap, tdi_tap;
  logic tck_rise, tck_fall;
  logic tdo_r, tdo_oe_r;
  logic we_seen_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Pad levels come from the board: two flops before use
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
    end else begin
      pin_s1_r <= pad_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Every pad powers up on code zero: port I/O, or debug on the JTAG pads
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_r <= {NUM_PADS{SEL_DEFAULT}}; // [RQ1] [RQ3]
    end else if (sel_we && sel_pad < PAD_W'(NUM_PADS)) begin
      sel_r[sel_pad] <= sel_val; // [RQ13]
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      we_seen_r <= 1'b0;
    end else if (sel_we) begin
      we_seen_r <= 1'b1;
    end
  end

  // Slave select is active low; deselected when not muxed in
  assign ss_sel = (fn_class(PAD_F7, sel_r[PAD_F7]) == FC_SSEL) && !pin_s2_r[PAD_F7];

  // Reassigned debug pads present the pulled-up idle level to the TAP
  assign tms_tap = (sel_r[PAD_TMS] == SEL_DEFAULT) ? pin_s2_r[PAD_TMS] : 1'b1;
  assign tdi_tap = (sel_r[PAD_TDI] == SEL_DEFAULT) ? pin_s2_r[PAD_TDI] : 1'b1;

  tap_tracker u_tap (
    .clk(clk),
    .rst_n(rst_n_r),
    .tck_pin(tck_pin),
    .tms(tms_tap),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall),
    .shift(tap_shift)
  );

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tap_bits <= '{tms: 1'b1, tdi: 1'b1, sample: 1'b0};
    end else begin
      tap_bits.sample <= tck_rise;
      if (tck_rise) begin
        tap_bits.tms <= tms_tap; // [RQ5]
        tap_bits.tdi <= tdi_tap; // [RQ6]
      end
    end
  end

  // Test data out moves only on falling debug clock
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= tdo_data; // [RQ4]
      tdo_oe_r <= tap_shift; // [RQ4]
    end
  end

  for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
    localparam logic PULL_RST = (i == PAD_TMS) || (i == PAD_TDI);
    fn_class_t cls;
    pad_drive_t drv_nxt;

    assign cls = fn_class(i, sel_r[i]);

    always_comb begin
      drv_nxt = '{dout: periph_dout[i][sel_r[i]], oe: 1'b0};
      case (cls)
        FC_GPIO: drv_nxt = '{dout: gpio_dout[i], oe: gpio_dir[i]}; // [RQ2]
        FC_OUT: drv_nxt.oe = 1'b1; // [RQ13]
        FC_BIDIR: drv_nxt.oe = periph_oe[i][sel_r[i]]; // [RQ12]
        FC_SCI_TX: drv_nxt.oe = serial_comm_port_1_single_wire ? periph_oe[i][sel_r[i]] : 1'b1; // [RQ11]
        FC_MISO: drv_nxt.oe = !serial_peripheral_port_1_master && ss_sel; // [RQ7]
        FC_MOSI: drv_nxt.oe = serial_peripheral_port_1_master; // [RQ8]
        FC_CLOCK_OUTPUT_SELECT_REGISTER: drv_nxt = '{dout: clk_src[clock_out_source_field], oe: 1'b1}; // [RQ10]
        FC_TDO: drv_nxt = '{dout: tdo_r, oe: tdo_oe_r}; // [RQ4]
        default: drv_nxt.oe = 1'b0; // [RQ14]
      endcase
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
        pad_out[i] <= 1'b0;
        pad_oe[i] <= 1'b0;
        pad_pull_up[i] <= PULL_RST;
        gpio_din[i] <= 1'b0;
      end else begin
        pad_out[i] <= drv_nxt.dout;
        pad_oe[i] <= drv_nxt.oe;
        pad_pull_up[i] <= (cls == FC_TMS) || (cls == FC_TDI); // [RQ5] [RQ6]
        gpio_din[i] <= (cls == FC_GPIO) ? pin_s2_r[i] : 1'b0;
      end
    end

    for (genvar f = 0; f < NUM_FN; f++) begin : g_fn
      localparam logic IDLE = idle_level(fn_class(i, SEL_W'(f)));
      always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          periph_din[i][f] <= IDLE;
        end else if (sel_r[i] == SEL_W'(f) && takes_input(cls)) begin
          periph_din[i][f] <= pin_s2_r[i]; // [RQ14]
        end else begin
          periph_din[i][f] <= IDLE; // [RQ13]
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_r);

  sequence s_fall_in_shift;
    tck_fall && tap_shift;
  endsequence

  sequence s_tdo_routed;
    sel_r[PAD_TDO] == SEL_DEFAULT;
  endsequence

  a_reset_sel_zero: assert property ( // [RQ1]
    !we_seen_r |-> sel_r == {NUM_PADS{SEL_DEFAULT}})
    else $error("pad select left its power-up code without a write");

  a_gpio_own_dir: assert property ( // [RQ2]
    sel_r[PAD_E0] == SEL_DEFAULT |=> pad_oe[PAD_E0] == $past(gpio_dir[PAD_E0]))
    else $error("port pad enable does not follow its own direction bit");

  a_jtag_tdi_pull: assert property ( // [RQ3]
    sel_r[PAD_TDI] == SEL_DEFAULT |=> pad_pull_up[PAD_TDI] && !pad_oe[PAD_TDI])
    else $error("debug input pad not pulled up or being driven");

  a_tdo_drive_shift: assert property ( // [RQ4]
    s_tdo_routed ##0 s_fall_in_shift |=> tdo_oe_r ##1 pad_oe[PAD_TDO])
    else $error("test data out not driven after falling edge in shift");

  a_tdo_on_fall: assert property ( // [RQ4]
    $changed(tdo_r) || $changed(tdo_oe_r) |-> $past(tck_fall))
    else $error("test data out moved away from a falling debug clock edge");

  a_tdo_float_idle: assert property ( // [RQ4]
    (tck_fall && !tap_shift) |=> !tdo_oe_r)
    else $error("test data out still driven outside shift states");

  a_tms_sample: assert property ( // [RQ5]
    tck_rise |=> tap_bits.sample && tap_bits.tms == $past(tms_tap))
    else $error("mode select not captured on rising debug clock");

  a_tdi_sample: assert property ( // [RQ6]
    tck_rise |=> tap_bits.tdi == $past(tdi_tap))
    else $error("data in not captured on rising debug clock");

  a_miso_float: assert property ( // [RQ7]
    (sel_r[PAD_F2] == SEL_ALT3 && !serial_peripheral_port_1_master && !ss_sel) |=> !pad_oe[PAD_F2])
    else $error("deselected slave drives its master-in line");

  a_mosi_dir: assert property ( // [RQ8]
    sel_r[PAD_F3] == SEL_ALT3 |=> pad_oe[PAD_F3] == $past(serial_peripheral_port_1_master))
    else $error("master-out pad direction does not follow master mode");

  a_clock_output_select_register_src: assert property ( // [RQ10]
    sel_r[PAD_F1] == SEL_ALT1
      |=> pad_oe[PAD_F1] && pad_out[PAD_F1] == $past(clk_src[clock_out_source_field]))
    else $error("clock-out pad not driving the selected source");

  a_sci_tx_mode: assert property ( // [RQ11]
    (sel_r[PAD_F4] == SEL_ALT1 && !serial_comm_port_1_single_wire) |=> pad_oe[PAD_F4])
    else $error("plain transmit pad not driven");

  a_pwm_bidir: assert property ( // [RQ12]
    sel_r[PAD_E1] == SEL_ALT1 |=> pad_oe[PAD_E1] == $past(periph_oe[PAD_E1][SEL_ALT1]))
    else $error("PWM pad enable does not follow its submodule");

  a_unsel_idle: assert property ( // [RQ13]
    sel_r[PAD_F5] != SEL_ALT1 |=> periph_din[PAD_F5][SEL_ALT1] == 1'b0)
    else $error("unselected receive input does not see idle level");

  a_fault_no_drive: assert property ( // [RQ14]
    sel_r[PAD_F4] == SEL_ALT4
      |=> !pad_oe[PAD_F4] && periph_din[PAD_F4][SEL_ALT4] == $past(pin_s2_r[PAD_F4]))
    else $error("fault pad driven or level not forwarded");

  a_in_no_drive: assert property ( // [RQ13]
    sel_r[PAD_F5] == SEL_ALT1
      |=> !pad_oe[PAD_F5] && periph_din[PAD_F5][SEL_ALT1] == $past(pin_s2_r[PAD_F5]))
    else $error("receive-only pad driven or level not forwarded");

  a_out_drive: assert property ( // [RQ13]
    sel_r[PAD_F2] == SEL_ALT2
      |=> pad_oe[PAD_F2] && pad_out[PAD_F2] == $past(periph_dout[PAD_F2][SEL_ALT2]))
    else $error("output-only function not reaching its pad");

  a_out_no_listen: assert property ( // [RQ13]
    sel_r[PAD_F2] == SEL_ALT2 |=> periph_din[PAD_F2][SEL_ALT2] == 1'b0)
    else $error("output-only function sees the pad level");

  a_tdi_slot_idle: assert property ( // [RQ13]
    sel_r[PAD_TDI] != SEL_DEFAULT |=> periph_din[PAD_TDI][SEL_DEFAULT] == 1'b1)
    else $error("reassigned debug data input not held at idle high");

  a_ssel_slot_idle: assert property ( // [RQ13]
    sel_r[PAD_F7] != SEL_ALT3 |=> periph_din[PAD_F7][SEL_ALT3] == 1'b1)
    else $error("unselected slave select not held deselected");

  a_gpio_din_gate: assert property ( // [RQ1]
    sel_r[PAD_F4] != SEL_DEFAULT |=> gpio_din[PAD_F4] == 1'b0)
    else $error("port input follows a pad given to another function");

  a_gpio_out_data: assert property ( // [RQ2]
    sel_r[PAD_E0] == SEL_DEFAULT |=> pad_out[PAD_E0] == $past(gpio_dout[PAD_E0]))
    else $error("port pad data does not follow its port bit");

  a_sci_shared_dir: assert property ( // [RQ11]
    (sel_r[PAD_F4] == SEL_ALT1 && serial_comm_port_1_single_wire)
      |=> pad_oe[PAD_F4] == $past(periph_oe[PAD_F4][SEL_ALT1]))
    else $error("single-wire transmit pad ignores its direction");

  a_miso_drive: assert property ( // [RQ7]
    (sel_r[PAD_F2] == SEL_ALT3 && !serial_peripheral_port_1_master && ss_sel)
      |=> pad_oe[PAD_F2] && pad_out[PAD_F2] == $past(periph_dout[PAD_F2][SEL_ALT3]))
    else $error("selected slave does not drive its master-in line");

  a_tms_pull_up: assert property ( // [RQ5]
    sel_r[PAD_TMS] == SEL_DEFAULT |=> pad_pull_up[PAD_TMS] && !pad_oe[PAD_TMS])
    else $error("mode select pad not pulled up or being driven");

  a_tdo_port_dir: assert property ( // [RQ3]
    sel_r[PAD_TDO] == SEL_ALT1 |=> pad_oe[PAD_TDO] == $past(gpio_dir[PAD_TDO]))
    else $error("reassigned test data out pad ignores its direction bit");

  a_bad_code_float: assert property ( // [RQ13]
    sel_r[PAD_E0] > SEL_ALT1 |=> !pad_oe[PAD_E0])
    else $error("pad driven under an unused select code");

  a_pwm_capture: assert property ( // [RQ12]
    sel_r[PAD_E1] == SEL_ALT1 |=> periph_din[PAD_E1][SEL_ALT1] == $past(pin_s2_r[PAD_E1]))
    else $error("PWM capture input does not see the pad level");

endmodule : pin_function_mux

// >>> hdl/pin_mux_pkg.sv
package pin_mux_pkg;

  // Pad set and select geometry
  localparam int NUM_PADS = 12;
  localparam int NUM_FN = 8;
  localparam int SEL_W = 3;
  localparam int PAD_W = 4;
  localparam int CLK_SRC_N = 4;
  localparam int CLK_SRC_W = 2;

  // Pad positions
  localparam int PAD_F2 = 0;
  localparam int PAD_F3 = 1;
  localparam int PAD_F4 = 2;
  localparam int PAD_F5 = 3;
  localparam int PAD_E0 = 4;
  localparam int PAD_E1 = 5;
  localparam int PAD_F1 = 6;
  localparam int PAD_F7 = 7;
  localparam int PAD_C13 = 8;
  localparam int PAD_TDO = 9;
  localparam int PAD_TMS = 10;
  localparam int PAD_TDI = 11;

  // Select codes; code zero is each pad's power-up function
  localparam logic [SEL_W-1:0] SEL_DEFAULT = 3'h0;
  localparam logic [SEL_W-1:0] SEL_ALT1 = 3'h1;
  localparam logic [SEL_W-1:0] SEL_ALT2 = 3'h2;
  localparam logic [SEL_W-1:0] SEL_ALT3 = 3'h3;
  localparam logic [SEL_W-1:0] SEL_ALT4 = 3'h4;

  typedef enum logic [3:0] {
    FC_NONE, FC_GPIO, FC_OUT, FC_IN, FC_BIDIR, FC_MISO, FC_MOSI, FC_SSEL,
    FC_CLOCK_OUTPUT_SELECT_REGISTER, FC_SCI_TX, FC_FAULT, FC_TDO, FC_TMS, FC_TDI
  } fn_class_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic dout;
    logic oe;
  } pad_drive_t;

  typedef struct packed {
    logic tms;
    logic tdi;
    logic sample;
  } tap_bits_t;

  // Function class of a pad under a given select code
  function automatic fn_class_t fn_class(input int pad, input logic [SEL_W-1:0] sel);
    fn_class_t c;
    c = (sel == SEL_DEFAULT) ? FC_GPIO : FC_NONE;
    case (pad)
      PAD_F2: case (sel)
        SEL_ALT1: c = FC_BIDIR;
        SEL_ALT2: c = FC_OUT;
        SEL_ALT3: c = FC_MISO;
        default: c = c;
      endcase
      PAD_F3: case (sel)
        SEL_ALT1: c = FC_BIDIR;
        SEL_ALT2: c = FC_OUT;
        SEL_ALT3: c = FC_MOSI;
        default: c = c;
      endcase
      PAD_F4, PAD_F5: case (sel)
        SEL_ALT1: c = (pad == PAD_F4) ? FC_SCI_TX : FC_IN;
        SEL_ALT2: c = FC_OUT;
        SEL_ALT3: c = FC_BIDIR;
        SEL_ALT4: c = FC_FAULT;
        default: c = c;
      endcase
      PAD_E0, PAD_E1: c = (sel == SEL_ALT1) ? FC_BIDIR : c;
      PAD_F1: case (sel)
        SEL_ALT1: c = FC_CLOCK_OUTPUT_SELECT_REGISTER;
        SEL_ALT2: c = FC_IN;
        SEL_ALT3: c = FC_OUT;
        default: c = c;
      endcase
      PAD_F7: case (sel)
        SEL_ALT1: c = FC_BIDIR;
        SEL_ALT2: c = FC_OUT;
        SEL_ALT3: c = FC_SSEL;
        SEL_ALT4: c = FC_IN;
        default: c = c;
      endcase
      PAD_C13: case (sel)
        SEL_ALT1: c = FC_BIDIR;
        SEL_ALT2: c = FC_IN;
        SEL_ALT3: c = FC_OUT;
        default: c = c;
      endcase
      PAD_TDO: c = (sel == SEL_DEFAULT) ? FC_TDO : (sel == SEL_ALT1) ? FC_GPIO : FC_NONE;
      PAD_TMS: c = (sel == SEL_DEFAULT) ? FC_TMS : (sel == SEL_ALT1) ? FC_GPIO : FC_NONE;
      PAD_TDI: c = (sel == SEL_DEFAULT) ? FC_TDI : (sel == SEL_ALT1) ? FC_GPIO : FC_NONE;
      default: c = FC_NONE;
    endcase
    return c;
  endfunction : fn_class

  // Level a function's input sees while it is not selected
  function automatic logic idle_level(input fn_class_t c);
    return (c == FC_SSEL) || (c == FC_TMS) || (c == FC_TDI);
  endfunction : idle_level

  function automatic logic takes_input(input fn_class_t c);
    case (c)
      FC_IN, FC_BIDIR, FC_SCI_TX, FC_MISO, FC_MOSI: return 1'b1;
      FC_SSEL, FC_FAULT, FC_TMS, FC_TDI: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : takes_input

endpackage : pin_mux_pkg

// >>> hdl/tap_tracker.sv
`timescale 1ns/1ps
module tap_tracker
  import pin_mux_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Debug clock pin and mode select
  input wire logic tck_pin,
  input wire logic tms,
  // Edge pulses and state
  output logic tck_rise,
  output logic tck_fall,
  output logic shift
);

  logic tck_s1_r, tck_s2_r, tck_s3_r;
  tap_state_t state_r;

  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    case (s)
      TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: return m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: return m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: return m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: return m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: return m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: return m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: return m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: return m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: return m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_IDLE;
      default: return TAP_RESET;
    endcase
  endfunction : tap_next

  // Debug clock is foreign to clk: two flops, then an edge stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_s3_r <= 1'b0;
    end else begin
      tck_s1_r <= tck_pin;
      tck_s2_r <= tck_s1_r;
      tck_s3_r <= tck_s2_r;
    end
  end

  assign tck_rise = tck_s2_r && !tck_s3_r;
  assign tck_fall = !tck_s2_r && tck_s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TAP_RESET;
    end else if (tck_rise) begin
      state_r <= tap_next(state_r, tms); // [RQ5]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= 1'b0;
    end else begin
      shift <= (state_r == TAP_SHIFT_DR) || (state_r == TAP_SHIFT_IR);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_tap_dr_exit: assert property ( // [RQ5]
    (state_r == TAP_SHIFT_DR && tck_rise && tms) |=> state_r == TAP_EXIT1_DR)
    else $error("shift-DR did not leave on rising edge with mode select high");

  a_tap_hold_edge: assert property ( // [RQ5]
    !tck_rise |=> $stable(state_r))
    else $error("TAP state moved without a rising debug clock edge");

endmodule : tap_tracker
